// ### verilog/shift_unit_pkg.sv
// Constants and types for the universal shift unit register core
`default_nettype none
package shift_unit_pkg;
	// Register byte addresses on the APB bus
	localparam logic [11:0] OFS_SHIFT_DATA     = 12'h000;
	localparam logic [11:0] OFS_RECEIVE_BUFFER = 12'h004;
	localparam logic [11:0] OFS_SERIAL_STATUS  = 12'h008;
	localparam logic [11:0] OFS_SERIAL_CONTROL = 12'h00c;
	localparam int          ADDR_W             = 12;
	localparam int          DATA_W             = 32;
	localparam int          REG_W              = 8;
	localparam int          CNT_W              = 4;
	// Reset values and counter maximum
	localparam logic [7:0]  RST_BYTE           = 8'h00;
	localparam logic [3:0]  RST_CNT            = 4'h0;
	localparam logic [3:0]  CNT_MAX            = 4'hf;
	localparam logic [1:0]  PIN_IDLE           = 2'h3;
	// serial_status fields
	localparam int          ST_START           = 7;
	localparam int          ST_OVF             = 6;
	localparam int          ST_STOP            = 5;
	localparam int          ST_COLL            = 4;
	localparam int          ST_CNT_HI          = 3;
	localparam int          ST_CNT_LO          = 0;
	// serial_control fields
	localparam int          CT_SIE             = 7;
	localparam int          CT_OIE             = 6;
	localparam int          CT_WM_HI           = 5;
	localparam int          CT_WM_LO           = 4;
	localparam int          CT_CS_HI           = 3;
	localparam int          CT_CS_LO           = 2;
	localparam int          CT_SWCLK           = 1;
	localparam int          CT_TOGGLE          = 0;
	// Wire modes, in field encoding order
	typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} wire_mode_t;
	// Clock sources, in field encoding order
	typedef enum logic [1:0] {CS_SOFT, CS_TIMER, CS_EXT_POS, CS_EXT_NEG} clock_source_t;
endpackage
`default_nettype wire

// ### verilog/universal_shift_unit.sv
// Universal shift unit: shift register, counter, two-wire detectors, APB registers
// Function
// - Start detector works only in the two two-wire modes.
// - Start detection needs no clock enable and can signal deep-sleep wake.
// - External clock counts the 4-bit counter on both pin edges.
// - Software write to shift data beats a coincident shift.
// - Shift left on selected clock: pin edge, timer match or soft strobe.
// - Data output comes from shift data bit 7 through a latch.
// - Latch open first half-cycle with external clock, always with internal.
// - New bit 7 written reaches output at once while latch open.
// - Completed transfer copies shift data into receive buffer.
// - Start flag: start condition, or any clock edge in off/three-wire external while swclk clear.
// - Start interrupt requested while flag, enable and global enable set.
// - Start flag cleared by writing one; clearing releases held clock line.
// - Start interrupt can wake from every sleep state.
// - Counter wrap 15 to 0 sets overflow flag; interrupt when enabled.
// - Overflow flag cleared by writing one; releases overflow clock hold.
// - Overflow interrupt wakes only from idle sleep.
// - Two-wire stop condition sets stop flag; write one clears; no interrupt.
// - Collision bit shows bit 7 differing from sampled data pin.
// - Counter readable, writable, increments once per selected clock.
// - Software clock bit with external source moves counting to toggle strobe.
// - Pending flag requests interrupt as soon as enables are set.
// - Wire mode: off, three-wire, two-wire, two-wire with overflow hold.
// - Clock source: soft strobe, timer match, external positive or negative.
`default_nettype none
module universal_shift_unit
	import shift_unit_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic                   pready,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pslverr,
	// Core-side events and enables
	input  wire logic              global_irq_enable,
	input  wire logic              timer_compare_match,
	output logic                   start_irq,
	output logic                   overflow_irq,
	output logic                   wake_any_sleep,
	output logic                   wake_idle_only,
	// Serial pins
	input  wire logic              serial_in_pin,
	input  wire logic              serial_clock_pin,
	output logic                   data_out,
	output logic                   data_out_oe,
	output logic                   sda_out,
	output logic                   sda_oe,
	output logic                   scl_out,
	output logic                   scl_oe
);

	// Pin synchronisers: meta stage read only by the sync stage
	logic [1:0] pin_meta_ff;
	logic [1:0] pin_sync_ff;
	logic [1:0] pin_last_ff;

	// Registers
	logic [REG_W-1:0] shift_ff;
	logic [REG_W-1:0] rxbuf_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             start_flag_ff;
	logic             ovf_flag_ff;
	logic             stop_flag_ff;
	logic             sie_ff;
	logic             oie_ff;
	logic [1:0]       wm_ff;
	logic [1:0]       cs_ff;
	logic             swclk_ff;
	logic             latch_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	logic [REG_W-1:0] prdata_ff;
	logic             start_irq_ff;
	logic             ovf_irq_ff;
	logic             scl_hold_ff;
	logic             data_out_ff;
	logic             data_oe_ff;
	logic             sda_oe_ff;

	// Sampled pin levels and edges
	wire sda_s    = pin_sync_ff[0];
	wire scl_s    = pin_sync_ff[1];
	wire sda_rise = pin_sync_ff[0] & ~pin_last_ff[0];
	wire sda_fall = ~pin_sync_ff[0] & pin_last_ff[0];
	wire scl_rise = pin_sync_ff[1] & ~pin_last_ff[1];
	wire scl_fall = ~pin_sync_ff[1] & pin_last_ff[1];

	// Decoded modes
	wire_mode_t    wire_mode;
	clock_source_t clock_src;
	assign wire_mode = wire_mode_t'(wm_ff);
	assign clock_src = clock_source_t'(cs_ff);
	wire two_wire = (wire_mode == WM_TWO) | (wire_mode == WM_TWO_HOLD);
	wire ext_clk  = cs_ff[1];

	// APB decode, shared by read mux and write strobes
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		addr_hit = (a == ofs);
	endfunction
	wire hit_data   = addr_hit(paddr, OFS_SHIFT_DATA);
	wire hit_rxbuf  = addr_hit(paddr, OFS_RECEIVE_BUFFER);
	wire hit_status = addr_hit(paddr, OFS_SERIAL_STATUS);
	wire hit_ctrl   = addr_hit(paddr, OFS_SERIAL_CONTROL);
	wire hit_any    = hit_data | hit_rxbuf | hit_status | hit_ctrl;
	wire apb_setup  = psel & ~penable;
	wire apb_wr     = psel & penable & pready_ff & pwrite & hit_any;
	wire wr_data    = apb_wr & hit_data;
	wire wr_status  = apb_wr & hit_status;
	wire wr_ctrl    = apb_wr & hit_ctrl;
	wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];

	// Strobe bits of serial_control act only on the write; swclk is also stored, toggle never
	wire soft_strobe   = wr_ctrl & wbyte[CT_SWCLK];
	wire toggle_strobe = wr_ctrl & wbyte[CT_TOGGLE];

	// Shift clock select
	wire ext_shift_edge = (clock_src == CS_EXT_POS) ? scl_rise : scl_fall;
	wire shift_clk = ((clock_src == CS_SOFT) & soft_strobe)
		| ((clock_src == CS_TIMER) & timer_compare_match)
		| (ext_clk & ext_shift_edge);
	// Counter clock: both pin edges, or toggle strobe once swclk is set;
	// a write that sets swclk already counts its own toggle, as a software master needs
	wire swclk_now    = wr_ctrl ? wbyte[CT_SWCLK] : swclk_ff;
	wire ext_cnt_edge = swclk_now ? toggle_strobe : (scl_rise | scl_fall);
	wire cnt_clk = ((clock_src == CS_SOFT) & soft_strobe)
		| ((clock_src == CS_TIMER) & timer_compare_match)
		| (ext_clk & ext_cnt_edge);

	// Shift path: write wins over shift
	wire [REG_W-1:0] shifted = {shift_ff[REG_W-2:0], sda_s};
	wire [REG_W-1:0] nxt_shift = wr_data ? wbyte
		: (shift_clk ? shifted : shift_ff);

	// Counter and overflow; a software write to the count wins
	wire             cnt_wrap = cnt_clk & (cnt_ff == CNT_MAX) & ~wr_status;
	wire [CNT_W-1:0] cnt_inc  = cnt_ff + 4'h1;
	wire [CNT_W-1:0] nxt_cnt  = wr_status ? wbyte[ST_CNT_HI:ST_CNT_LO]
		: (cnt_clk ? cnt_inc : cnt_ff);

	// Start and stop conditions, sampled while clock line high
	wire start_cond = two_wire & scl_s & sda_fall;
	wire stop_cond  = two_wire & scl_s & sda_rise;
	wire edge_start = ~two_wire & ext_clk & ~swclk_ff & (scl_rise | scl_fall);
	wire set_start  = start_cond | edge_start;

	// Flags: hardware set wins over software clear
	wire nxt_start_flag = set_start | (start_flag_ff & ~(wr_status & wbyte[ST_START]));
	wire nxt_ovf_flag   = cnt_wrap | (ovf_flag_ff & ~(wr_status & wbyte[ST_OVF]));
	wire nxt_stop_flag  = stop_cond | (stop_flag_ff & ~(wr_status & wbyte[ST_STOP]));

	// Collision compares bit 7 against the sampled line
	wire collision = shift_ff[REG_W-1] ^ sda_s;

	// Output latch open: internal clock always, external on first half-cycle
	wire latch_open = ~ext_clk
		| ((clock_src == CS_EXT_POS) ? ~scl_s : scl_s);
	// Open latch passes the next bit 7 so a write shows at once
	wire nxt_latch = latch_open ? nxt_shift[REG_W-1] : latch_ff;

	// Clock hold: start hold after master's falling edge, overflow hold in mode 11
	wire nxt_scl_hold = two_wire & ((nxt_start_flag & ~scl_s)
		| ((wire_mode == WM_TWO_HOLD) & nxt_ovf_flag));

	// Interrupt requests follow the flags, so a pending flag fires on enable
	wire nxt_start_irq = start_flag_ff & sie_ff & global_irq_enable;
	wire nxt_ovf_irq   = ovf_flag_ff & oie_ff & global_irq_enable;

	// Read mux; strobe bits read as zero, upper bits zero
	wire [REG_W-1:0] status_rd = {start_flag_ff, ovf_flag_ff, stop_flag_ff, collision, cnt_ff};
	wire [REG_W-1:0] ctrl_rd   = {sie_ff, oie_ff, wm_ff, cs_ff, 2'b00};
	wire [REG_W-1:0] rd_mux    = hit_data ? shift_ff
		: hit_rxbuf ? rxbuf_ff
		: hit_status ? status_rd
		: hit_ctrl ? ctrl_rd : RST_BYTE;

	// Pin synchronisers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta_ff <= PIN_IDLE; // Idle bus level, so no false edge after reset
			pin_sync_ff <= PIN_IDLE;
			pin_last_ff <= PIN_IDLE;
		end else begin
			pin_meta_ff <= {serial_clock_pin, serial_in_pin};
			pin_sync_ff <= pin_meta_ff;
			pin_last_ff <= pin_sync_ff;
		end
	end

	// APB answer: one wait-free access phase after each setup
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= RST_BYTE;
		end else begin
			pready_ff  <= apb_setup;
			pslverr_ff <= apb_setup & ~hit_any;
			prdata_ff  <= apb_setup ? rd_mux : prdata_ff;
		end
	end

	// Shift data and receive buffer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_ff <= RST_BYTE;
			rxbuf_ff <= RST_BYTE;
		end else begin
			shift_ff <= nxt_shift;
			if (cnt_wrap) begin
				rxbuf_ff <= nxt_shift;
			end
		end
	end

	// Counter and flags
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff        <= RST_CNT;
			start_flag_ff <= 1'b0;
			ovf_flag_ff   <= 1'b0;
			stop_flag_ff  <= 1'b0;
		end else begin
			cnt_ff        <= nxt_cnt;
			start_flag_ff <= nxt_start_flag;
			ovf_flag_ff   <= nxt_ovf_flag;
			stop_flag_ff  <= nxt_stop_flag;
		end
	end

	// Control register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sie_ff   <= 1'b0;
			oie_ff   <= 1'b0;
			wm_ff    <= WM_OFF;
			cs_ff    <= CS_SOFT;
			swclk_ff <= 1'b0;
		end else if (wr_ctrl) begin
			sie_ff   <= wbyte[CT_SIE];
			oie_ff   <= wbyte[CT_OIE];
			wm_ff    <= wbyte[CT_WM_HI:CT_WM_LO];
			cs_ff    <= wbyte[CT_CS_HI:CT_CS_LO];
			swclk_ff <= wbyte[CT_SWCLK];
		end
	end

	// Pin drivers and interrupt outputs, all registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			latch_ff     <= 1'b0;
			data_out_ff  <= 1'b0;
			data_oe_ff   <= 1'b0;
			sda_oe_ff    <= 1'b0;
			scl_hold_ff  <= 1'b0;
			start_irq_ff <= 1'b0;
			ovf_irq_ff   <= 1'b0;
		end else begin
			latch_ff     <= nxt_latch;
			data_out_ff  <= nxt_latch;
			data_oe_ff   <= (wire_mode == WM_THREE);
			sda_oe_ff    <= two_wire & ~nxt_latch; // Open drain: pull low only
			scl_hold_ff  <= nxt_scl_hold;
			start_irq_ff <= nxt_start_irq;
			ovf_irq_ff   <= nxt_ovf_irq;
		end
	end

	assign pready         = pready_ff;
	assign pslverr        = pslverr_ff;
	assign prdata         = {{(DATA_W-REG_W){1'b0}}, prdata_ff};
	assign start_irq      = start_irq_ff;
	assign overflow_irq   = ovf_irq_ff;
	// Start wake reaches every sleep depth; overflow only idle
	assign wake_any_sleep = start_irq_ff;
	assign wake_idle_only = ovf_irq_ff;
	assign data_out       = data_out_ff;
	assign data_out_oe    = data_oe_ff;
	assign sda_out        = 1'b0;
	assign sda_oe         = sda_oe_ff;
	assign scl_out        = 1'b0;
	assign scl_oe         = scl_hold_ff;

	// Checks on the guarded behaviour
	chk_write_beats_shift: assert property (@(posedge clk) disable iff (reset)
		wr_data |=> shift_ff == $past(wbyte)) else $error("shift write lost");
	chk_shift_left_in: assert property (@(posedge clk) disable iff (reset)
		(shift_clk && !wr_data) |=> shift_ff == {$past(shift_ff[REG_W-2:0]), $past(sda_s)})
		else $error("shift wrong");
	chk_ovf_on_wrap: assert property (@(posedge clk) disable iff (reset)
		(cnt_clk && cnt_ff == CNT_MAX && !wr_status) |=> ovf_flag_ff && cnt_ff == RST_CNT)
		else $error("overflow missed");
	chk_rxbuf_copy: assert property (@(posedge clk) disable iff (reset)
		$rose(ovf_flag_ff) |-> rxbuf_ff == shift_ff) else $error("buffer not copied");
	chk_start_mode: assert property (@(posedge clk) disable iff (reset)
		(!two_wire && !(ext_clk && !swclk_ff)) |=> !$rose(start_flag_ff))
		else $error("start flag outside mode");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (reset)
		(start_flag_ff && !(wr_status && wbyte[ST_START])) |=> start_flag_ff)
		else $error("start flag dropped");
	chk_start_irq: assert property (@(posedge clk) disable iff (reset)
		(start_flag_ff && sie_ff && global_irq_enable) |=> start_irq && wake_any_sleep)
		else $error("start irq missing");
	chk_stop_no_irq: assert property (@(posedge clk) disable iff (reset)
		(stop_flag_ff && !start_flag_ff && !ovf_flag_ff) |=> !start_irq && !overflow_irq)
		else $error("stop raised irq");
	// A clear of the flag in the same cycle lets the hold go, so it is left out
	chk_ovf_hold: assert property (@(posedge clk) disable iff (reset)
		(wire_mode == WM_TWO_HOLD && ovf_flag_ff && !(wr_status && wbyte[ST_OVF])) |=> scl_oe)
		else $error("no overflow hold");
	chk_collision: assert property (@(posedge clk) disable iff (reset)
		status_rd[ST_COLL] == (shift_ff[REG_W-1] != sda_s)) else $error("collision wrong");
	chk_latch_internal: assert property (@(posedge clk) disable iff (reset)
		(!ext_clk && !$past(ext_clk)) |-> data_out == $past(nxt_shift[REG_W-1]))
		else $error("latch not transparent");
	chk_start_set: assert property (@(posedge clk) disable iff (reset)
		(two_wire && scl_s && sda_fall) |=> start_flag_ff)
		else $error("start condition missed");
	chk_edge_start: assert property (@(posedge clk) disable iff (reset)
		(!two_wire && ext_clk && !swclk_ff && (scl_rise || scl_fall)) |=> start_flag_ff)
		else $error("clock edge start missed");
	chk_stop_set: assert property (@(posedge clk) disable iff (reset)
		(two_wire && scl_s && sda_rise) |=> stop_flag_ff)
		else $error("stop condition missed");
	chk_stop_sticky: assert property (@(posedge clk) disable iff (reset)
		(stop_flag_ff && !(wr_status && wbyte[ST_STOP])) |=> stop_flag_ff)
		else $error("stop flag dropped");
	chk_ovf_sticky: assert property (@(posedge clk) disable iff (reset)
		(ovf_flag_ff && !(wr_status && wbyte[ST_OVF])) |=> ovf_flag_ff)
		else $error("overflow flag dropped");
	chk_ovf_irq: assert property (@(posedge clk) disable iff (reset)
		(ovf_flag_ff && oie_ff && global_irq_enable) |=> overflow_irq && wake_idle_only)
		else $error("overflow irq missing");
	chk_irq_masked: assert property (@(posedge clk) disable iff (reset)
		!global_irq_enable |=> !start_irq && !overflow_irq)
		else $error("irq without global enable");
	chk_start_hold: assert property (@(posedge clk) disable iff (reset)
		(two_wire && start_flag_ff && !scl_s && !(wr_status && wbyte[ST_START])) |=> scl_oe)
		else $error("no start hold");
	chk_hold_off: assert property (@(posedge clk) disable iff (reset)
		!two_wire |=> !scl_oe && !sda_oe)
		else $error("line driven outside two-wire");
	chk_count_step: assert property (@(posedge clk) disable iff (reset)
		(cnt_clk && !wr_status) |=> cnt_ff == CNT_W'($past(cnt_ff) + 1'b1))
		else $error("counter step wrong");
	chk_count_write: assert property (@(posedge clk) disable iff (reset)
		wr_status |=> cnt_ff == $past(wbyte[ST_CNT_HI:ST_CNT_LO]))
		else $error("counter write lost");
	chk_both_edges: assert property (@(posedge clk) disable iff (reset)
		(ext_clk && !swclk_ff && !wr_ctrl && (scl_rise || scl_fall)) |-> cnt_clk)
		else $error("pin edge not counted");
	chk_toggle_count: assert property (@(posedge clk) disable iff (reset)
		(ext_clk && wr_ctrl && wbyte[CT_SWCLK] && wbyte[CT_TOGGLE]) |-> cnt_clk)
		else $error("toggle not counted");
	chk_rxbuf_ro: assert property (@(posedge clk) disable iff (reset)
		!cnt_wrap |=> rxbuf_ff == $past(rxbuf_ff))
		else $error("buffer changed without transfer");
	chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
		(ext_clk && !latch_open) |=> $stable(data_out))
		else $error("closed latch changed");
	chk_latch_open_ext: assert property (@(posedge clk) disable iff (reset)
		(ext_clk && latch_open) |=> data_out == $past(nxt_shift[REG_W-1]))
		else $error("open latch not passing");
	chk_sda_follows: assert property (@(posedge clk) disable iff (reset)
		two_wire |=> sda_oe == !data_out)
		else $error("data line drive wrong");
	chk_three_oe: assert property (@(posedge clk) disable iff (reset)
		(wire_mode == WM_THREE) |=> data_out_oe)
		else $error("data output not enabled");

endmodule
`default_nettype wire

// ### verif/serial_peer.sv
// Behavioural serial peer that masters the clock and data lines of the shift unit
`default_nettype none
module serial_peer (
	// Lines as the peer drives them, high means released
	output var logic sck,
	output var logic sdo,
	// Resolved clock line, watched for clock stretching
	input  wire logic scl_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// Both lines idle at the pull-up level; the clock stands still between frames
	initial begin
		sck = 1'b1;
		sdo = 1'b1;
	end

	// MSB first: data changes on the fall so it is stable at the rise
	task automatic frame(input logic [7:0] d);
		#1; // Stay off the clock edge on which the task is called
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			sdo = d[i];
			#62.5;
			sck = 1'b1;
			wait (scl_line === 1'b1); // A held clock must be let go first
			#62.5;
		end
		sdo = 1'b1; // Released data line goes back to the pull-up
	endtask

	// Data falls while the clock is high, then the clock falls
	task automatic start_cond();
		#1;
		sdo = 1'b0;
		#62.5;
		sck = 1'b0;
		#62.5;
	endtask

	// Data rises while the clock is high
	task automatic stop_cond();
		#1;
		sdo = 1'b0;
		#62.5;
		sck = 1'b1;
		#62.5;
		sdo = 1'b1;
		#62.5;
	endtask

	task automatic set_sck(input logic v);
		#1;
		sck = v;
		#62.5;
	endtask
endmodule
`default_nettype wire

// ### verif/universal_shift_unit_tb.sv
// Self-checking bench for the universal shift unit
`default_nettype none
module universal_shift_unit_tb import shift_unit_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic              clk, reset, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdat;
	logic              global_irq_enable, timer_compare_match, rerr;
	logic              start_irq, overflow_irq, wake_any_sleep, wake_idle_only;
	logic              serial_in_pin, serial_clock_pin, peer_sck, peer_sdo;
	logic              data_out, data_out_oe, sda_out, sda_oe, scl_out, scl_oe;
	int                errors = 0;
	int                checks_done = 0;

	universal_shift_unit universal_shift_unit_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .global_irq_enable, .timer_compare_match, .start_irq,
		.overflow_irq, .wake_any_sleep, .wake_idle_only, .serial_in_pin, .serial_clock_pin, .data_out,
		.data_out_oe, .sda_out, .sda_oe, .scl_out, .scl_oe);
	serial_peer serial_peer_inst (.sck(peer_sck), .sdo(peer_sdo), .scl_line(serial_clock_pin));

	// Open-drain wires: a driving unit pulls to its out value, else the peer decides
	assign serial_clock_pin = scl_oe ? (scl_out & peer_sck) : peer_sck;
	assign serial_in_pin    = sda_oe ? (sda_out & peer_sdo) : peer_sdo;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; tm pulses the timer match in the access cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic tm);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		timer_compare_match <= tm;
		n = 0;
		do begin
			@(posedge clk);
			timer_compare_match <= 1'b0;
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) errors++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
		apb(1'b0, a, 8'h00, 1'b0);
		chk(nm, rdat, {24'h0, exp});
	endtask

	task automatic t_reset();
		rd(OFS_SHIFT_DATA, 8'h00, "shift_data");
		rd(OFS_RECEIVE_BUFFER, 8'h00, "receive_buffer");
		rd(OFS_SERIAL_STATUS, 8'h10, "serial_status");
		rd(OFS_SERIAL_CONTROL, 8'h00, "serial_control");
		wr(OFS_RECEIVE_BUFFER, 8'h5a);
		rd(OFS_RECEIVE_BUFFER, 8'h00, "buffer read only");
		apb(1'b0, 12'h010, 8'h00, 1'b0);
		chk("unmapped error", {31'h0, rerr}, 32'h1);
		chk("unmapped data", rdat, 32'h0);
	endtask

	task automatic t_soft();
		wr(OFS_SHIFT_DATA, 8'h80);
		wr(OFS_SERIAL_CONTROL, 8'h10);
		repeat (3) @(posedge clk);
		chk("data_out", {data_out_oe, data_out}, 2'b11);
		wr(OFS_SERIAL_STATUS, 8'h0f); // Counter at maximum
		wr(OFS_SERIAL_CONTROL, 8'h12);
		rd(OFS_SERIAL_CONTROL, 8'h10, "strobe bits");
		rd(OFS_SHIFT_DATA, 8'h01, "soft shift");
		rd(OFS_RECEIVE_BUFFER, 8'h01, "buffer copy");
		rd(OFS_SERIAL_STATUS, 8'h50, "wrap");
		chk("new msb", data_out, 1'b0);
		chk("irq masked", overflow_irq, 1'b0);
		wr(OFS_SERIAL_CONTROL, 8'h50);
		repeat (3) @(posedge clk);
		chk("irq pending", {overflow_irq, wake_idle_only, wake_any_sleep}, 3'b110);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("global mask", overflow_irq, 1'b0);
		global_irq_enable <= 1'b1;
		wr(OFS_SERIAL_STATUS, 8'h40);
		rd(OFS_SERIAL_STATUS, 8'h10, "w1c");
		chk("irq cleared", overflow_irq, 1'b0);
	endtask

	task automatic t_timer();
		wr(OFS_SERIAL_CONTROL, 8'h04);
		wr(OFS_SHIFT_DATA, 8'h33);
		timer_compare_match <= 1'b1;
		@(posedge clk);
		timer_compare_match <= 1'b0;
		rd(OFS_SHIFT_DATA, 8'h67, "timer shift");
		apb(1'b1, OFS_SHIFT_DATA, 8'hc3, 1'b1);
		rd(OFS_SHIFT_DATA, 8'hc3, "write beats shift");
		rd(OFS_SERIAL_STATUS, 8'h02, "timer count");
	endtask

	task automatic t_three();
		wr(OFS_SERIAL_STATUS, 8'hf0);
		wr(OFS_SHIFT_DATA, 8'h00);
		wr(OFS_SERIAL_CONTROL, 8'h18);
		serial_peer_inst.frame(8'ha5);
		repeat (8) @(posedge clk);
		chk("latch closed", {data_out_oe, data_out}, 2'h2);
		rd(OFS_SHIFT_DATA, 8'ha5, "external shift");
		rd(OFS_RECEIVE_BUFFER, 8'ha5, "external buffer");
		rd(OFS_SERIAL_STATUS, 8'hc0, "both edges");
		wr(OFS_SERIAL_CONTROL, 8'h98);
		repeat (3) @(posedge clk);
		chk("start irq", {start_irq, wake_any_sleep}, 2'b11);
		wr(OFS_SERIAL_STATUS, 8'hc0);
		wr(OFS_SERIAL_CONTROL, 8'h1b);
		wr(OFS_SERIAL_CONTROL, 8'h1b);
		rd(OFS_SERIAL_STATUS, 8'h02, "toggle count");
		rd(OFS_SHIFT_DATA, 8'ha5, "no toggle shift");
	endtask

	task automatic t_two();
		wr(OFS_SHIFT_DATA, 8'hff);
		wr(OFS_SERIAL_CONTROL, 8'hfc);
		wr(OFS_SERIAL_STATUS, 8'hf0);
		serial_peer_inst.start_cond();
		repeat (8) @(posedge clk);
		rd(OFS_SERIAL_STATUS, 8'h91, "start detect");
		chk("start hold", {scl_oe, start_irq}, 2'b11);
		wr(OFS_SERIAL_STATUS, 8'hf0);
		repeat (3) @(posedge clk);
		chk("start release", scl_oe, 1'b0);
		serial_peer_inst.stop_cond();
		repeat (8) @(posedge clk);
		rd(OFS_SERIAL_STATUS, 8'h21, "stop detect");
		chk("stop no irq", {start_irq, overflow_irq}, 2'b00);
		wr(OFS_SERIAL_STATUS, 8'h2f); // Counter at maximum
		serial_peer_inst.set_sck(1'b0);
		repeat (8) @(posedge clk);
		chk("overflow hold", {scl_oe, overflow_irq}, 2'b11);
		wr(OFS_SERIAL_STATUS, 8'h40);
		repeat (3) @(posedge clk);
		chk("overflow release", scl_oe, 1'b0);
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, timer_compare_match} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		global_irq_enable = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_soft();
		t_timer();
		t_three();
		t_two();
		end_sim();
	end

	// Watchdog: the whole run needs well under 100 us
	initial begin
		#100us;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
